// ===== common/mux_seq_pkg.sv
package mux_seq_pkg;
  // register offsets on the plain byte-wide port
  localparam logic [7:0] off_mode_status = 8'h1C;
  localparam logic [7:0] off_manual_channel = 8'h1D;
  localparam logic [7:0] off_sequence_start = 8'h1E;
  localparam logic [7:0] off_sequence_stop = 8'h1F;
  localparam logic [7:0] off_common_input = 8'h27;
  localparam logic [7:0] off_live_enable = 8'h2A;
  localparam logic [7:0] off_scan_enables = 8'h80;
  localparam logic [7:0] off_scan_loop = 8'h82;

  // field positions
  localparam int pos_alert_level = 3;
  localparam int pos_config_error = 2;
  localparam int pos_mode_lsb = 0;
  localparam int pos_common_bit = 0;
  localparam int pos_start_bit = 0;
  localparam int pos_stop_bit = 0;
  localparam int pos_live_bit = 0;
  localparam int pos_loop_bit = 0;

  // reset values
  localparam logic [1:0] rst_mode = 2'h0;
  localparam logic [2:0] rst_manual_channel = 3'h0;
  localparam logic rst_common = 1'b0;
  localparam logic rst_live = 1'b0;
  localparam logic [7:0] rst_scan_enables = 8'h00;
  localparam logic rst_loop = 1'b0;

  // pairing field codes
  localparam logic [1:0] pair_separate = 2'h0;
  localparam logic [1:0] pair_single = 2'h1;
  localparam logic [1:0] pair_pseudo = 2'h2;
  localparam logic [1:0] pair_separate_alt = 2'h3;

  // pin synchroniser depth
  localparam int sync_stages = 3;

  typedef enum logic [1:0] {
    mode_manual = 2'h0,
    mode_live = 2'h1,
    mode_auto = 2'h2,
    mode_custom = 2'h3
  } seq_mode_t;

  typedef enum logic [1:0] {
    seq_idle = 2'b01,
    seq_run = 2'b10
  } seq_state_t;
endpackage

// ===== design/mux_seq_regs.sv
`timescale 1ns/10ps
module mux_seq_regs #(
  parameter int channels = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic alarm_pin,
  input wire logic config_error,
  input wire logic [7:0] input_pairing_config,
  input wire logic [4:0] live_code,
  input wire logic live_code_valid,
  output logic [1:0] sequencing_mode_field,
  output logic [2:0] manual_channel_select,
  output logic [2:0] selected_channel,
  output logic [channels-1:0] channel_pseudo_diff,
  output logic [channels/2-1:0] negative_to_common,
  output logic [channels-1:0] scan_channel_enables,
  output logic scan_loop,
  output logic live_select_enable,
  output logic sequence_active,
  output logic start_pulse,
  output logic abort_pulse
);

  // pairing field of one pair, low pair in the low bits
  function automatic logic [1:0] pair_field(input logic [7:0] cfg, input int p);
    pair_field = cfg[2*p +: 2];
  endfunction

  // decoded write strobe for one offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
    hit = s && (a == off);
  endfunction

  logic [1:0] mode;
  logic [2:0] manual_ch;
  logic [2:0] live_ch;
  logic common_bit;
  logic live_en;
  logic [7:0] scan_en;
  logic loop_en;
  logic [mux_seq_pkg::sync_stages-1:0] alarm_sync;
  logic alarm_level;
  mux_seq_pkg::seq_state_t seq_state;
  mux_seq_pkg::seq_state_t next_seq_state;
  logic wr_mode;
  logic wr_manual;
  logic wr_start;
  logic wr_stop;
  logic seq_mode_active;
  logic manual_abort;

  assign wr_mode = hit(addr, mux_seq_pkg::off_mode_status, wr);
  assign wr_manual = hit(addr, mux_seq_pkg::off_manual_channel, wr);
  assign wr_start = hit(addr, mux_seq_pkg::off_sequence_start, wr) &&
    wdata[mux_seq_pkg::pos_start_bit];
  assign wr_stop = hit(addr, mux_seq_pkg::off_sequence_stop, wr) &&
    wdata[mux_seq_pkg::pos_stop_bit];
  // start and stop only matter while a sequencing mode is selected
  assign seq_mode_active = (mode == mux_seq_pkg::mode_auto) ||
    (mode == mux_seq_pkg::mode_custom);
  assign manual_abort = wr_manual && seq_mode_active;

  // mode field; status bits in the same write are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= mux_seq_pkg::rst_mode;
    end else if (manual_abort) begin
      mode <= mux_seq_pkg::mode_manual;
    end else if (wr_mode) begin
      mode <= wdata[mux_seq_pkg::pos_mode_lsb +: 2];
    end
  end

  // manual channel code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manual_ch <= mux_seq_pkg::rst_manual_channel;
    end else if (wr_manual) begin
      manual_ch <= wdata[2:0];
    end
  end

  // plain configuration bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      common_bit <= mux_seq_pkg::rst_common;
      live_en <= mux_seq_pkg::rst_live;
      scan_en <= mux_seq_pkg::rst_scan_enables;
      loop_en <= mux_seq_pkg::rst_loop;
    end else begin
      if (hit(addr, mux_seq_pkg::off_common_input, wr)) begin
        common_bit <= wdata[mux_seq_pkg::pos_common_bit];
      end
      if (hit(addr, mux_seq_pkg::off_live_enable, wr)) begin
        live_en <= wdata[mux_seq_pkg::pos_live_bit];
      end
      if (hit(addr, mux_seq_pkg::off_scan_enables, wr)) begin
        scan_en <= wdata;
      end
      if (hit(addr, mux_seq_pkg::off_scan_loop, wr)) begin
        loop_en <= wdata[mux_seq_pkg::pos_loop_bit];
      end
    end
  end

  // alarm pin: three stages, level moves only when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_sync <= '0;
      alarm_level <= 1'b0;
    end else begin
      alarm_sync <= {alarm_sync[1:0], alarm_pin};
      if (alarm_sync[1] == alarm_sync[2]) begin
        alarm_level <= alarm_sync[2];
      end
    end
  end

  // live channel code from the serial front end, low three bits pick input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_ch <= 3'h0;
    end else if (live_code_valid && live_en) begin
      live_ch <= live_code[2:0];
    end
  end

  // sequence run state; stop and manual abort beat a start
  always_comb begin
    next_seq_state = seq_state;
    unique case (seq_state)
      mux_seq_pkg::seq_idle: begin
        if (wr_start && seq_mode_active && !wr_stop && !manual_abort) begin
          next_seq_state = mux_seq_pkg::seq_run;
        end
      end
      mux_seq_pkg::seq_run: begin
        if (wr_stop || manual_abort || !seq_mode_active) begin
          next_seq_state = mux_seq_pkg::seq_idle;
        end
      end
      default: begin
        next_seq_state = mux_seq_pkg::seq_idle;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_state <= mux_seq_pkg::seq_idle;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // one-cycle start and abort strobes to the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
    end else begin
      start_pulse <= (seq_state == mux_seq_pkg::seq_idle) &&
        (next_seq_state == mux_seq_pkg::seq_run);
      abort_pulse <= (seq_state == mux_seq_pkg::seq_run) &&
        (next_seq_state == mux_seq_pkg::seq_idle);
    end
  end

  // read data stand one cycle after the read strobe; write-only reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        mux_seq_pkg::off_mode_status:
          rdata <= {4'h0, alarm_level, config_error, mode};
        mux_seq_pkg::off_manual_channel:
          rdata <= {5'h00, manual_ch};
        mux_seq_pkg::off_common_input:
          rdata <= {7'h00, common_bit};
        mux_seq_pkg::off_live_enable:
          rdata <= {7'h00, live_en};
        mux_seq_pkg::off_scan_enables:
          rdata <= scan_en;
        mux_seq_pkg::off_scan_loop:
          rdata <= {7'h00, loop_en};
        default:
          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // channel type per input; pairs use their own type, others follow common bit
  always_comb begin
    logic [1:0] f;
    f = 2'h0;
    for (int i = 0; i < channels; i++) begin
      f = pair_field(input_pairing_config, i / 2);
      if (f == mux_seq_pkg::pair_separate || f == mux_seq_pkg::pair_separate_alt) begin
        channel_pseudo_diff[i] = common_bit;
      end else begin
        channel_pseudo_diff[i] = (f == mux_seq_pkg::pair_pseudo);
      end
    end
  end

  // negative mux output follows the common pin for separated pairs
  always_comb begin
    for (int p = 0; p < channels / 2; p++) begin
      negative_to_common[p] =
        (pair_field(input_pairing_config, p) == mux_seq_pkg::pair_separate) ||
        (pair_field(input_pairing_config, p) == mux_seq_pkg::pair_separate_alt);
    end
  end

  // input that the mux passes when no sequence drives it
  assign selected_channel = (mode == mux_seq_pkg::mode_live && live_en) ?
    live_ch : manual_ch;

  assign sequencing_mode_field = mode;
  assign manual_channel_select = manual_ch;
  assign scan_channel_enables = scan_en;
  assign scan_loop = loop_en;
  assign live_select_enable = live_en;
  assign sequence_active = (seq_state == mux_seq_pkg::seq_run);

  // status read shows the pieces from the cycle of the strobe
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == mux_seq_pkg::off_mode_status) |=>
    rdata == {4'h0, $past(alarm_level), $past(config_error), $past(mode)})
    else $error("status read does not match state");

  a_status_reserved: assert property (@(posedge clk) disable iff (rst)
    $past(rd && addr == mux_seq_pkg::off_mode_status) |-> rdata[7:4] == 4'h0)
    else $error("status reserved bits not zero");

  a_common_reserved: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == mux_seq_pkg::off_common_input) |=> rdata[7:1] == 7'h00)
    else $error("common reserved bits not zero");

  a_manual_reserved: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == mux_seq_pkg::off_manual_channel) |=>
    (rdata[7:3] == 5'h00 && rdata[2:0] == manual_channel_select))
    else $error("manual select read wrong");

  a_mode_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == mux_seq_pkg::off_mode_status) |=> mode == $past(wdata[1:0]))
    else $error("mode field not written");

  a_abort_to_manual: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == mux_seq_pkg::off_manual_channel && seq_mode_active) |=>
    (mode == mux_seq_pkg::mode_manual && !sequence_active))
    else $error("manual write did not abort sequence");

  a_start_runs: assert property (@(posedge clk) disable iff (rst)
    (wr_start && seq_mode_active && !wr_stop && !sequence_active) |=>
    (sequence_active && start_pulse))
    else $error("start did not run sequence");

  a_stop_halts: assert property (@(posedge clk) disable iff (rst)
    (wr_stop && sequence_active) |=> (!sequence_active ##0 abort_pulse))
    else $error("stop did not halt sequence");

  a_unpaired_common: assert property (@(posedge clk) disable iff (rst)
    (input_pairing_config[1:0] == mux_seq_pkg::pair_separate) |->
    (channel_pseudo_diff[1:0] == {2{common_bit}} && negative_to_common[0]))
    else $error("unpaired pair ignores common bit");

  a_alarm_follow: assert property (@(posedge clk) disable iff (rst)
    alarm_pin [*5] |-> alarm_level)
    else $error("alarm level not following pin");

  a_live_select: assert property (@(posedge clk) disable iff (rst)
    (live_code_valid && live_en && mode == mux_seq_pkg::mode_live &&
    !(wr && addr == mux_seq_pkg::off_mode_status) &&
    !(wr && addr == mux_seq_pkg::off_live_enable)) |=>
    selected_channel == $past(live_code[2:0]))
    else $error("live code not selected");

  a_live_ignored: assert property (@(posedge clk) disable iff (rst)
    (live_code_valid && !live_en) |=>
    live_ch == $past(live_ch))
    else $error("live code taken while disabled");

  a_start_refused: assert property (@(posedge clk) disable iff (rst)
    (wr_start && !seq_mode_active && !sequence_active) |=>
    (!sequence_active && !start_pulse))
    else $error("start accepted outside sequencing mode");

  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    (wr_stop && !sequence_active) |=> (!sequence_active && !abort_pulse))
    else $error("stop while idle had an effect");

  a_common_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == mux_seq_pkg::off_common_input) |=>
    common_bit == $past(wdata[mux_seq_pkg::pos_common_bit]))
    else $error("common bit not written");

endmodule // mux_seq_regs

// ===== sim/host_model.sv
`timescale 1ns/10ps
// host side: drives the register port and the live channel code
module host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic [4:0] live_code,
  output logic live_code_valid
);
  // idle bus at time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    live_code = 5'h00;
    live_code_valid = 1'b0;
  end

  // one-cycle write; reserved mode bits never written
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= (a == mux_seq_pkg::off_mode_status) ? {4'h0, d[3:0]} : d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // released lines show the inverse so stale values never pass
    addr <= ~a;
    wdata <= ~d;
    @(negedge clk);
  endtask

  // data stands only in the cycle after the strobe, taken mid-cycle
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask

  // five serial bits picking the next channel, one-cycle valid
  task automatic live_send(input logic [4:0] code);
    @(posedge clk);
    live_code <= code;
    live_code_valid <= 1'b1;
    @(posedge clk);
    live_code_valid <= 1'b0;
    live_code <= ~code;
    @(negedge clk);
  endtask
endmodule // host_model

// ===== sim/adc_mux_sequencer_config_tb_top.sv
`timescale 1ns/10ps
module adc_mux_sequencer_config_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic alarm_pin = 1'b0;
  logic config_error = 1'b0;
  logic [7:0] input_pairing_config = 8'h00;
  logic [7:0] addr, wdata, rdata, scan_en;
  logic wr, rd, live_valid, scan_loop, live_en, active, start_p, abort_p;
  logic [4:0] live_code;
  logic [1:0] mode_field;
  logic [2:0] manual_ch, sel_ch;
  logic [7:0] pseudo;
  logic [3:0] neg_com;
  int n_fail = 0;
  int total_checks = 0;

  always #12.5 clk = ~clk;

  mux_seq_regs DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .alarm_pin(alarm_pin), .config_error(config_error),
    .input_pairing_config(input_pairing_config), .live_code(live_code),
    .live_code_valid(live_valid), .sequencing_mode_field(mode_field),
    .manual_channel_select(manual_ch), .selected_channel(sel_ch),
    .channel_pseudo_diff(pseudo), .negative_to_common(neg_com),
    .scan_channel_enables(scan_en), .scan_loop(scan_loop), .live_select_enable(live_en),
    .sequence_active(active), .start_pulse(start_p), .abort_pulse(abort_p));

  host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .live_code(live_code), .live_code_valid(live_valid));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.bus_read(a, d);
    chk(d, exp, "register read");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reset values, write-only places and an unmapped offset all read zero
  task automatic t_reset;
    rd_chk(mux_seq_pkg::off_mode_status, 8'h00);
    rd_chk(mux_seq_pkg::off_manual_channel, 8'h00);
    rd_chk(mux_seq_pkg::off_common_input, 8'h00);
    rd_chk(mux_seq_pkg::off_sequence_start, 8'h00);
    rd_chk(mux_seq_pkg::off_sequence_stop, 8'h00);
    rd_chk(8'h55, 8'h00);
    rd_chk(mux_seq_pkg::off_live_enable, 8'h00);
    rd_chk(mux_seq_pkg::off_scan_enables, 8'h00);
    rd_chk(mux_seq_pkg::off_scan_loop, 8'h00);
    $display("test reset done");
  endtask

  // pairs: 0 separate, 1 single-ended pair, 2 pseudo pair, 3 separate alt
  task automatic t_common;
    @(posedge clk);
    input_pairing_config <= 8'hE4;
    host.bus_write(mux_seq_pkg::off_common_input, 8'hFF);
    rd_chk(mux_seq_pkg::off_common_input, 8'h01);
    chk(pseudo, 8'hF3, "pseudo with common set");
    chk({4'h0, neg_com}, 8'h09, "negative to common");
    host.bus_write(mux_seq_pkg::off_common_input, 8'h00);
    chk(pseudo, 8'h30, "pseudo with common clear");
    $display("test common done");
  endtask

  // every mode code, status bits written high must not stick
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      host.bus_write(mux_seq_pkg::off_mode_status, {6'h03, m[1:0]});
      rd_chk(mux_seq_pkg::off_mode_status, {6'h00, m[1:0]});
      chk({6'h00, mode_field}, {6'h00, m[1:0]}, "mode field");
    end
    @(posedge clk);
    alarm_pin <= 1'b1;
    config_error <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(mux_seq_pkg::off_mode_status, 8'h0F);
    @(posedge clk);
    config_error <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(mux_seq_pkg::off_mode_status, 8'h0B);
    @(posedge clk);
    alarm_pin <= 1'b0;
    config_error <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(mux_seq_pkg::off_mode_status, 8'h07);
    @(posedge clk);
    config_error <= 1'b0;
    $display("test mode done");
  endtask

  // each channel code with reserved bits set on the write
  task automatic t_manual;
    host.bus_write(mux_seq_pkg::off_mode_status, 8'h00);
    for (int c = 0; c < 8; c++) begin
      host.bus_write(mux_seq_pkg::off_manual_channel, {5'h1F, c[2:0]});
      rd_chk(mux_seq_pkg::off_manual_channel, {5'h00, c[2:0]});
      chk({5'h00, sel_ch}, {5'h00, c[2:0]}, "selected channel");
    end
    $display("test manual done");
  endtask

  // scan setup, start refused in manual, stop, then abort by manual write
  task automatic t_seq;
    host.bus_write(mux_seq_pkg::off_scan_enables, 8'hA5);
    rd_chk(mux_seq_pkg::off_scan_enables, 8'hA5);
    chk(scan_en, 8'hA5, "scan enables out");
    host.bus_write(mux_seq_pkg::off_scan_loop, 8'hFF);
    rd_chk(mux_seq_pkg::off_scan_loop, 8'h01);
    chk({7'h00, scan_loop}, 8'h01, "scan loop out");
    host.bus_write(mux_seq_pkg::off_sequence_start, 8'h01);
    chk({6'h00, start_p, active}, 8'h00, "start in manual");
    host.bus_write(mux_seq_pkg::off_mode_status, 8'h02);
    host.bus_write(mux_seq_pkg::off_sequence_start, 8'h01);
    chk({6'h00, start_p, active}, 8'h03, "started");
    host.bus_write(mux_seq_pkg::off_sequence_stop, 8'h01);
    chk({6'h00, abort_p, active}, 8'h02, "stopped");
    host.bus_write(mux_seq_pkg::off_sequence_start, 8'h01);
    host.bus_write(mux_seq_pkg::off_manual_channel, 8'h03);
    chk({6'h00, abort_p, active}, 8'h02, "manual abort");
    host.bus_write(mux_seq_pkg::off_sequence_stop, 8'h01);
    chk({6'h00, abort_p, active}, 8'h00, "stop when idle");
    rd_chk(mux_seq_pkg::off_mode_status, 8'h00);
    chk({5'h00, manual_ch}, 8'h03, "manual after abort");
    $display("test sequence done");
  endtask

  // live code honoured only while enabled
  task automatic t_live;
    host.bus_write(mux_seq_pkg::off_live_enable, 8'hFF);
    rd_chk(mux_seq_pkg::off_live_enable, 8'h01);
    chk({7'h00, live_en}, 8'h01, "live enable out");
    host.bus_write(mux_seq_pkg::off_mode_status, 8'h01);
    host.live_send(5'h1E);
    chk({5'h00, sel_ch}, 8'h06, "live pick");
    host.bus_write(mux_seq_pkg::off_live_enable, 8'h00);
    host.live_send(5'h01);
    chk({5'h00, sel_ch}, 8'h03, "manual while disabled");
    host.bus_write(mux_seq_pkg::off_live_enable, 8'h01);
    chk({5'h00, sel_ch}, 8'h06, "live code refused");
    $display("test live done");
  endtask

  // reset in mid-run brings the registers back to their reset values
  task automatic t_rerst;
    host.bus_write(mux_seq_pkg::off_common_input, 8'h01);
    host.bus_write(mux_seq_pkg::off_mode_status, 8'h02);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_chk(mux_seq_pkg::off_common_input, 8'h00);
    rd_chk(mux_seq_pkg::off_mode_status, 8'h00);
    chk({5'h00, sel_ch}, 8'h00, "channel after reset");
    $display("test mid-run reset done");
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_common();
    t_mode();
    t_manual();
    t_seq();
    t_live();
    t_rerst();
    stop_test();
  end
endmodule // adc_mux_sequencer_config_tb_top
